/* File: src/mpt_top.sv */
// Purpose: pwm time base, special event compare, pin ownership and write lock
// Assumes: single-word AHB-Lite transfers; pwm drive levels come from duty logic outside
// Notes:   reads take one wait state so a read right after a write sees the new value
//
// Decided for this implementation: the AHB-Lite interface to the registers and the register offsets.
`timescale 1ns/100ps
module mpt_top
(
  input  wire logic                  CORE_CLK_IN,
  input  wire logic                  RST_B_IN,
  input  wire mpt_pkg::mpt_ahb_req_t AHB_REQ_IN,
  input  wire logic [31:0]           HWDATA_IN,
  output logic [31:0]                HRDATA_OUT,
  output logic                       HREADYOUT_OUT,
  output logic                       HRESP_OUT,
  input  wire logic                  CPU_IDLE_IN,
  input  wire logic                  RESET_PIN_OWNERSHIP_CONFIG_IN,
  input  wire logic                  WRITE_PROTECT_CONFIG_IN,
  input  wire logic                  FAULT_INPUT_A_B_IN,
  input  wire logic                  FAULT_INPUT_B_B_IN,
  input  wire logic [2:0]            PAIR_HIGH_DRIVE_IN,
  input  wire logic [2:0]            PAIR_LOW_DRIVE_IN,
  output mpt_pkg::mpt_pins_t         PINS_OUT,
  output logic                       TIMEBASE_EVENT_OUT,
  output logic                       SPECIAL_EVENT_OUT
);
  import mpt_pkg::*;

  // bus state
  mpt_phase_t  ph;
  mpt_phase_t  next_ph;
  logic [7:0]  dp_addr;
  logic [7:0]  next_dp_addr;
  logic        dp_hit;
  logic        next_dp_hit;
  logic [31:0] hrdata;
  logic [31:0] next_hrdata;
  logic        accept;

  // core state
  mpt_tbctl_t  ctl;
  mpt_tbctl_t  next_ctl;
  logic [14:0] cnt;
  logic [14:0] next_cnt;
  logic        dir;
  logic        next_dir;
  logic [14:0] per;
  logic [14:0] next_per;
  logic [14:0] sec_cmp;
  logic [14:0] next_sec_cmp;
  logic        sec_dir;
  logic        next_sec_dir;
  logic [2:0]  pair_independent_select;
  logic [2:0]  next_pair_independent_select;
  logic [2:0]  penh;
  logic [2:0]  next_penh;
  logic [2:0]  penl;
  logic [2:0]  next_penl;
  logic        pen_init;
  logic        next_pen_init;
  mpt_key_t    key;
  mpt_key_t    next_key;
  logic        flt_a;
  logic        next_flt_a;
  logic        flt_b;
  logic        next_flt_b;
  logic [5:0]  presc;
  logic [5:0]  next_presc;
  logic [3:0]  post;
  logic [3:0]  next_post;
  logic        tb_evt;
  logic        next_tb_evt;
  logic        sev;
  logic        next_sev;
  logic        moved;
  logic        next_moved;
  mpt_pins_t   pins;
  mpt_pins_t   next_pins;

  // decoded strobes
  logic        wr_fire;
  logic        acc_fire;
  logic        cnt_wr;
  logic        prot_ok;
  logic        run;
  logic        tick;
  logic        top_evt;
  logic        bot_evt;
  logic        post_evt;
  logic [15:0] wdata;
  logic [15:0] rd_word;
  logic [2:0]  drv_hi;
  logic [2:0]  drv_lo;
  logic        faulted;

  assign wdata    = HWDATA_IN[15:0];
  assign wr_fire  = (ph == PH_WRITE) && dp_hit;
  assign acc_fire = (ph == PH_WRITE) || (ph == PH_RDWAIT);
  assign cnt_wr   = wr_fire && (dp_addr == OFS_CNT);
  assign prot_ok  = !WRITE_PROTECT_CONFIG_IN || (key == KEY_OPEN);
  assign accept   = AHB_REQ_IN.hsel && AHB_REQ_IN.htrans[1] && AHB_REQ_IN.hready;
  assign faulted  = flt_a || flt_b;

  assign HREADYOUT_OUT      = (ph != PH_RDWAIT);
  assign HRESP_OUT          = 1'b0;
  assign HRDATA_OUT         = hrdata;
  assign PINS_OUT           = pins;
  assign TIMEBASE_EVENT_OUT = tb_evt;
  assign SPECIAL_EVENT_OUT  = sev;

  // bus slave: writes complete in their data phase, reads after one wait state
  always_comb
  begin
    next_ph      = ph;
    next_dp_addr = dp_addr;
    next_dp_hit  = dp_hit;
    next_hrdata  = hrdata;
    case (ph)
      PH_RDWAIT:
      begin
        next_ph     = PH_RDDONE;
        next_hrdata = {16'h0000, rd_word};
      end
      PH_IDLE, PH_WRITE, PH_RDDONE:
      begin
        if (accept)
        begin
          next_ph      = AHB_REQ_IN.hwrite ? PH_WRITE : PH_RDWAIT;
          next_dp_addr = AHB_REQ_IN.haddr[7:0];
          next_dp_hit  = (AHB_REQ_IN.haddr[31:8] == 24'h000000);
        end
        else
        begin
          next_ph = PH_IDLE;
        end
      end
      default: next_ph = PH_IDLE;
    endcase
  end

  always_ff @(posedge CORE_CLK_IN or negedge RST_B_IN)
  begin
    if (!RST_B_IN)
    begin
      ph      <= PH_IDLE;
      dp_addr <= 8'h00;
      dp_hit  <= 1'b0;
      hrdata  <= 32'h00000000;
    end
    else
    begin
      ph      <= next_ph;
      dp_addr <= next_dp_addr;
      dp_hit  <= next_dp_hit;
      hrdata  <= next_hrdata;
    end
  end

  // read mux; unmapped and unimplemented positions give zero
  always_comb
  begin
    rd_word = 16'h0000;
    if (dp_hit)
    begin
      case (dp_addr)
        OFS_CTL:  rd_word = {ctl.en, 1'b0, ctl.idle_halt, 5'h00, ctl.ops, ctl.ckps,
                             ctl.mode};
        OFS_CNT:  rd_word = {dir, cnt};
        OFS_PER:  rd_word = {1'b0, per};
        OFS_SEC:  rd_word = {sec_dir, sec_cmp};
        OFS_PAIR: rd_word = {5'h00, pair_independent_select, 1'b0, penh, 1'b0, penl};
        OFS_FLT:  rd_word = {14'h0000, flt_b, flt_a};
        default:  rd_word = 16'h0000;
      endcase
    end
  end

  // pin drive: complementary pairs derive low from high; a latched fault parks all
  generate
    for (genvar i = 0; i < 3; i++)
    begin : g_pair
      assign drv_hi[i] = PAIR_HIGH_DRIVE_IN[i] && !faulted;
      assign drv_lo[i] = (pair_independent_select[i] ? PAIR_LOW_DRIVE_IN[i] : !PAIR_HIGH_DRIVE_IN[i])
                         && !faulted;
    end
  endgenerate

  // time base, registers, lock and faults
  always_comb
  begin
    next_ctl      = ctl;
    next_cnt      = cnt;
    next_dir      = dir;
    next_per      = per;
    next_sec_cmp  = sec_cmp;
    next_sec_dir  = sec_dir;
    next_pair_independent_select     = pair_independent_select;
    next_penh     = penh;
    next_penl     = penl;
    next_pen_init = 1'b1;
    next_key      = key;
    next_flt_a    = flt_a;
    next_flt_b    = flt_b;
    next_post     = post;
    next_tb_evt   = 1'b0;
    top_evt       = 1'b0;
    bot_evt       = 1'b0;

    run  = ctl.en && !(ctl.idle_halt && CPU_IDLE_IN);
    tick = run && (presc == mpt_presc_max(ctl.ckps));
    if (!run || tick)
      next_presc = 6'h00;
    else
      next_presc = presc + 6'h01;

    if (tick)
    begin
      case (ctl.mode)
        MODE_FREE:
        begin
          if (cnt >= per)
          begin
            next_cnt = 15'h0000;
            top_evt  = 1'b1;
          end
          else
            next_cnt = cnt + 15'h0001;
        end
        MODE_SINGLE:
        begin
          // one period, then the time base turns itself off
          if (cnt >= per)
          begin
            next_cnt    = 15'h0000;
            next_ctl.en = 1'b0;
            top_evt     = 1'b1;
          end
          else
            next_cnt = cnt + 15'h0001;
        end
        MODE_UPDN, MODE_UPDN_DBL:
        begin
          if (!dir)
          begin
            if (cnt >= per)
            begin
              next_dir = 1'b1;
              next_cnt = (cnt == 15'h0000) ? 15'h0000 : cnt - 15'h0001;
              top_evt  = 1'b1;
            end
            else
              next_cnt = cnt + 15'h0001;
          end
          else
          begin
            if (cnt == 15'h0000)
            begin
              next_dir = 1'b0;
              next_cnt = (per == 15'h0000) ? 15'h0000 : 15'h0001;
              bot_evt  = 1'b1;
            end
            else
              next_cnt = cnt - 15'h0001;
          end
        end
        default: next_cnt = cnt;
      endcase
    end

    // double-update mode reports both turning points, plain up/down only the bottom
    case (ctl.mode)
      MODE_UPDN_DBL: post_evt = top_evt || bot_evt;
      MODE_UPDN:     post_evt = bot_evt;
      default:       post_evt = top_evt;
    endcase
    if (post_evt)
    begin
      if (post == ctl.ops)
      begin
        next_post   = 4'h0;
        next_tb_evt = 1'b1;
      end
      else
        next_post = post + 4'h1;
    end

    next_moved = tick;
    next_sev   = moved && (cnt == sec_cmp) && (dir == sec_dir);

    // first cycle after reset release takes pin ownership from the strap
    if (!pen_init)
    begin
      next_penh = RESET_PIN_OWNERSHIP_CONFIG_IN ? PEN_NONE : PEN_ALL;
      next_penl = RESET_PIN_OWNERSHIP_CONFIG_IN ? PEN_NONE : PEN_ALL;
    end

    // every access, read or write, moves the key sequence on
    if (acc_fire)
    begin
      if (wr_fire && (dp_addr == OFS_KEY) && (wdata == KEY_FIRST))
        next_key = KEY_HALF;
      else if (wr_fire && (dp_addr == OFS_KEY) && (wdata == KEY_SECOND) && (key == KEY_HALF))
        next_key = KEY_OPEN;
      else
        next_key = KEY_IDLE;
    end

    if (wr_fire)
    begin
      case (dp_addr)
        OFS_CTL:
        begin
          next_ctl.en        = wdata[CTL_EN_BIT];
          next_ctl.idle_halt = wdata[CTL_IDLE_BIT];
          next_ctl.ops       = wdata[CTL_OPS_LSB +: 4];
          next_ctl.ckps      = wdata[CTL_CKPS_LSB +: 2];
          next_ctl.mode      = mpt_mode_t'(wdata[CTL_MOD_LSB +: 2]);
        end
        OFS_CNT: next_cnt = wdata[14:0];
        OFS_PER: next_per = wdata[14:0];
        OFS_SEC:
        begin
          next_sec_cmp = wdata[14:0];
          next_sec_dir = wdata[SEC_DIR_BIT];
        end
        OFS_PAIR:
        begin
          if (prot_ok)
          begin
            next_pair_independent_select = wdata[PAIR_PAIR_INDEPENDENT_SELECT_LSB +: 3];
            next_penh = wdata[PAIR_PENH_LSB +: 3];
            next_penl = wdata[PAIR_PENL_LSB +: 3];
          end
        end
        OFS_FLT:
        begin
          // clearing only takes when the fault pin is already released
          if (prot_ok && wdata[FLT_A_BIT] && FAULT_INPUT_A_B_IN)
            next_flt_a = 1'b0;
          if (prot_ok && wdata[FLT_B_BIT] && FAULT_INPUT_B_B_IN)
            next_flt_b = 1'b0;
        end
        default: next_per = per;
      endcase
    end

    // a fault arriving with a clear still latches
    if (!FAULT_INPUT_A_B_IN)
      next_flt_a = 1'b1;
    if (!FAULT_INPUT_B_B_IN)
      next_flt_b = 1'b1;

    next_pins.hi    = drv_hi;
    next_pins.lo    = drv_lo;
    next_pins.hi_oe = penh;
    next_pins.lo_oe = penl;
  end

  always_ff @(posedge CORE_CLK_IN or negedge RST_B_IN)
  begin
    if (!RST_B_IN)
    begin
      ctl      <= CTL_RST;
      cnt      <= CNT_RST;
      dir      <= 1'b0;
      per      <= PER_RST;
      sec_cmp  <= SEC_RST;
      sec_dir  <= 1'b0;
      pair_independent_select     <= PAIR_INDEPENDENT_SELECT_RST;
      penh     <= PEN_NONE;
      penl     <= PEN_NONE;
      pen_init <= 1'b0;
      key      <= KEY_IDLE;
      flt_a    <= 1'b1;
      flt_b    <= 1'b1;
      presc    <= 6'h00;
      post     <= 4'h0;
      tb_evt   <= 1'b0;
      sev      <= 1'b0;
      moved    <= 1'b0;
      pins     <= '0;
    end
    else
    begin
      ctl      <= next_ctl;
      cnt      <= next_cnt;
      dir      <= next_dir;
      per      <= next_per;
      sec_cmp  <= next_sec_cmp;
      sec_dir  <= next_sec_dir;
      pair_independent_select     <= next_pair_independent_select;
      penh     <= next_penh;
      penl     <= next_penl;
      pen_init <= next_pen_init;
      key      <= next_key;
      flt_a    <= next_flt_a;
      flt_b    <= next_flt_b;
      presc    <= next_presc;
      post     <= next_post;
      tb_evt   <= next_tb_evt;
      sev      <= next_sev;
      moved    <= next_moved;
      pins     <= next_pins;
    end
  end

  default clocking cb @(posedge CORE_CLK_IN); endclocking
  default disable iff (!RST_B_IN);

  tb_stopped_a: assert property (!ctl.en && !cnt_wr |=> $stable(cnt) && $stable(dir))
    else $error("count moved while time base disabled");
  idle_halt_a: assert property (ctl.idle_halt && CPU_IDLE_IN && !cnt_wr |=> $stable(cnt))
    else $error("count moved during idle halt");
  post_ratio_a: assert property (tb_evt |-> $past(post) == $past(ctl.ops))
    else $error("postscaled event at wrong ratio");
  presc_rate_a: assert property ($changed(cnt) && !$past(cnt_wr) |->
                                 $past(presc) == mpt_presc_max($past(ctl.ckps)))
    else $error("count stepped off the prescaler tick");
  free_wrap_a: assert property (tick && ctl.mode == MODE_FREE && cnt >= per && !cnt_wr
                                |=> cnt == 15'h0000)
    else $error("free-running count did not wrap");
  turn_down_a: assert property (tick && ctl.mode[1] && !dir && cnt >= per |=> dir)
    else $error("up/down count did not turn at period");
  sev_match_a: assert property (sev |-> $past(cnt == sec_cmp) && $past(dir == sec_dir))
    else $error("special event without qualified match");
  pair_lock_a: assert property (wr_fire && dp_addr == OFS_PAIR && !prot_ok
                                |=> $stable(pair_independent_select) && $stable(penh) && $stable(penl))
    else $error("locked pair control was written");
  ctl_zero_a: assert property (ph == PH_RDDONE && dp_addr == OFS_CTL
                               |-> HRDATA_OUT[14] == 1'b0 && HRDATA_OUT[12:8] == 5'h00)
    else $error("unimplemented control bits read nonzero");
  key_cancel_a: assert property (key == KEY_OPEN && acc_fire |=> key != KEY_OPEN)
    else $error("unlock outlived the access that follows it");

  updn_dbl_c: cover property (ctl.mode == MODE_UPDN_DBL && bot_evt ##[1:1000] tb_evt);
  sev_fire_c: cover property (sev && dir);
  unlock_c: cover property (key == KEY_OPEN ##2 $changed(penh));
  single_c: cover property (ctl.mode == MODE_SINGLE && $fell(ctl.en));

endmodule

/* File: src/mpt_pkg.sv */
// Purpose: shared constants, types and decode helpers for the motor pwm time base block
// Assumes: AHB-Lite register access, one 10 MHz core clock, 16-bit registers in 32-bit words
// Notes:   offsets are byte addresses; each register is the low half of its word
// How it works
// - time base counts only while the run enable bit is set
// - idle-halt bit set stops the time base while the cpu idles
// - 4-bit postscaler value n gives one event per n+1 period events
// - prescale codes 00..11 give count periods of 1, 4, 16, 64 clocks
// - mode 00 free-running, 01 single pulse, 10 continuous up/down
// - mode 11 up/down with events at both turning points
// - count register bit 15 reads direction, one when counting down
// - count register bits 14:0 hold the live count, software writable
// - period register holds a 15-bit period, bit 15 reads zero
// - special event fires when compare value equals the live count
// - special event also needs its direction bit equal to the direction
// - pair-mode bit one gives independent pair, zero gives complementary
// - pin enable one drives the pin from pwm, zero frees it
// - pair control writes ignored unless the unlock sequence precedes them
// - pin enables reset from the pin ownership configuration bit
// - unimplemented bits, including control bits 12:8, read zero
// - unlock is key 0xABCD then key 0x4321 written in order
// - protected write must be the next access after the second key
// - every reset leaves both fault inputs latched, outputs safe
package mpt_pkg;

  localparam logic [7:0]  OFS_CTL  = 8'h00;
  localparam logic [7:0]  OFS_CNT  = 8'h04;
  localparam logic [7:0]  OFS_PER  = 8'h08;
  localparam logic [7:0]  OFS_SEC  = 8'h0C;
  localparam logic [7:0]  OFS_PAIR = 8'h10;
  localparam logic [7:0]  OFS_KEY  = 8'h14;
  localparam logic [7:0]  OFS_FLT  = 8'h18;

  localparam int          CTL_EN_BIT    = 15;
  localparam int          CTL_IDLE_BIT  = 13;
  localparam int          CTL_OPS_LSB   = 4;
  localparam int          CTL_CKPS_LSB  = 2;
  localparam int          CTL_MOD_LSB   = 0;
  localparam int          CNT_DIR_BIT   = 15;
  localparam int          SEC_DIR_BIT   = 15;
  localparam int          PAIR_PAIR_INDEPENDENT_SELECT_LSB = 8;
  localparam int          PAIR_PENH_LSB = 4;
  localparam int          PAIR_PENL_LSB = 0;
  localparam int          FLT_A_BIT     = 0;
  localparam int          FLT_B_BIT     = 1;

  localparam logic [15:0] KEY_FIRST     = 16'hABCD;
  localparam logic [15:0] KEY_SECOND    = 16'h4321;

  localparam logic [14:0] CNT_RST       = 15'h0000;
  localparam logic [14:0] PER_RST       = 15'h0000;
  localparam logic [14:0] SEC_RST       = 15'h0000;
  localparam logic [2:0]  PAIR_INDEPENDENT_SELECT_RST      = 3'h0;
  localparam logic [2:0]  PEN_ALL       = 3'h7;
  localparam logic [2:0]  PEN_NONE      = 3'h0;

  localparam logic [5:0]  PRESC_MAX_1   = 6'h00;
  localparam logic [5:0]  PRESC_MAX_4   = 6'h03;
  localparam logic [5:0]  PRESC_MAX_16  = 6'h0F;
  localparam logic [5:0]  PRESC_MAX_64  = 6'h3F;

  typedef enum logic [1:0] {
    MODE_FREE     = 2'b00,
    MODE_SINGLE   = 2'b01,
    MODE_UPDN     = 2'b10,
    MODE_UPDN_DBL = 2'b11
  } mpt_mode_t;

  typedef enum logic [1:0] {
    KEY_IDLE = 2'b00,
    KEY_HALF = 2'b01,
    KEY_OPEN = 2'b10
  } mpt_key_t;

  typedef enum logic [1:0] {
    PH_IDLE   = 2'b00,
    PH_WRITE  = 2'b01,
    PH_RDWAIT = 2'b10,
    PH_RDDONE = 2'b11
  } mpt_phase_t;

  typedef struct packed {
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic        hready;
  } mpt_ahb_req_t;

  typedef struct packed {
    logic       en;
    logic       idle_halt;
    logic [3:0] ops;
    logic [1:0] ckps;
    mpt_mode_t  mode;
  } mpt_tbctl_t;

  localparam mpt_tbctl_t CTL_RST = '{en: 1'b0, idle_halt: 1'b0, ops: 4'h0, ckps: 2'h0,
                                     mode: MODE_FREE};

  typedef struct packed {
    logic [2:0] hi;
    logic [2:0] lo;
    logic [2:0] hi_oe;
    logic [2:0] lo_oe;
  } mpt_pins_t;

  function automatic logic [5:0] mpt_presc_max(input logic [1:0] code);
    case (code)
      2'b00:   mpt_presc_max = PRESC_MAX_1;
      2'b01:   mpt_presc_max = PRESC_MAX_4;
      2'b10:   mpt_presc_max = PRESC_MAX_16;
      default: mpt_presc_max = PRESC_MAX_64;
    endcase
  endfunction

endpackage

/* File: dv/mpt_power_stage.sv */
// Purpose: power stage and fault sensing seen from the pwm pins
// Assumes: fault lines are actively driven by the sensing circuit, low = fault
// Notes:   trip requests come from the bench; lines follow one clock later
`timescale 1ns/100ps
module mpt_power_stage
(
  input  wire logic       clk_in,
  input  wire logic [1:0] trip_in,
  output logic            fault_a_b_out,
  output logic            fault_b_b_out
);
  // sensor releases its line high once the trip is gone, before any clear
  always_ff @(posedge clk_in)
  begin
    fault_a_b_out <= ~trip_in[0];
    fault_b_b_out <= ~trip_in[1];
  end
endmodule

/* File: dv/tb_mpt_top.sv */
// Purpose: register level test of time base, event compare and pin control
// Assumes: AHB-Lite master that waits on hready, one 10 MHz clock
// Notes:   event gaps are measured in clock edges between pulses
`timescale 1ns/100ps
module tb_mpt_top;
  import mpt_pkg::*;
  logic         clk;
  logic         rst_b;
  logic         hsel;
  logic [7:0]   haddr;
  logic [1:0]   htrans;
  logic         hwrite;
  logic [31:0]  hwdata;
  logic [31:0]  hrdata;
  logic         hreadyout;
  logic         hresp;
  mpt_ahb_req_t req;
  logic         idle;
  logic         strap;
  logic         lock;
  logic [1:0]   trip;
  logic         flt_a_b;
  logic         flt_b_b;
  logic [2:0]   drv_hi;
  logic [2:0]   drv_lo;
  mpt_pins_t    pins;
  logic         tb_ev;
  logic         sp_ev;
  int           fails;
  int           n_compared;
  int           gap;
  int           k;
  logic [15:0]  rd;
  logic [15:0]  rd2;

  assign req = '{hsel: hsel, haddr: {24'h0, haddr}, htrans: htrans, hwrite: hwrite,
                 hsize: 3'h2, hready: hreadyout};

  mpt_top mpt_top_inst (
    .CORE_CLK_IN                  (clk),
    .RST_B_IN                     (rst_b),
    .AHB_REQ_IN                   (req),
    .HWDATA_IN                    (hwdata),
    .HRDATA_OUT                   (hrdata),
    .HREADYOUT_OUT                (hreadyout),
    .HRESP_OUT                    (hresp),
    .CPU_IDLE_IN                  (idle),
    .RESET_PIN_OWNERSHIP_CONFIG_IN(strap),
    .WRITE_PROTECT_CONFIG_IN      (lock),
    .FAULT_INPUT_A_B_IN           (flt_a_b),
    .FAULT_INPUT_B_B_IN           (flt_b_b),
    .PAIR_HIGH_DRIVE_IN           (drv_hi),
    .PAIR_LOW_DRIVE_IN            (drv_lo),
    .PINS_OUT                     (pins),
    .TIMEBASE_EVENT_OUT           (tb_ev),
    .SPECIAL_EVENT_OUT            (sp_ev)
  );

  mpt_power_stage mpt_power_stage_inst (
    .clk_in       (clk),
    .trip_in      (trip),
    .fault_a_b_out(flt_a_b),
    .fault_b_b_out(flt_b_b)
  );

  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic tally_and_finish();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      fails++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wait_ready();
    int n;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
      if (n > 20)
      begin
        fails++;
        tally_and_finish();
      end
    end while (hreadyout !== 1'b1);
  endtask

  task automatic xfer(input logic w, input logic [7:0] a, input logic [15:0] wd,
                      output logic [15:0] r);
    hsel   <= 1'b1;
    haddr  <= a;
    htrans <= 2'b10;
    hwrite <= w;
    wait_ready();
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= {16'h0, wd};
    wait_ready();
    r = hrdata[15:0];
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    logic [15:0] t;
    xfer(1'b1, a, d, t);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [15:0] e);
    logic [15:0] t;
    xfer(1'b0, a, 16'h0, t);
    check(t, e);
  endtask

  task automatic unlock();
    wr(OFS_KEY, KEY_FIRST);
    wr(OFS_KEY, KEY_SECOND);
  endtask

  // cyc = edges from entry up to the edge that samples the pulse
  task automatic wait_ev(input logic sel, output int cyc);
    cyc = 0;
    do
    begin
      @(posedge clk);
      cyc++;
      if (cyc > 3000)
      begin
        fails++;
        tally_and_finish();
      end
    end while ((sel ? sp_ev : tb_ev) !== 1'b1);
  endtask

  // stop first so the prescaler restarts from a clean phase
  task automatic start(input logic [1:0] m, input logic [1:0] c, input logic [3:0] o,
                       input logic [15:0] p);
    wr(OFS_CTL, 16'h0000);
    wr(OFS_CNT, 16'h0000);
    wr(OFS_PER, p);
    wr(OFS_CTL, {8'h80, o, c, m});
  endtask

  task automatic reset(input logic s);
    strap <= s;
    rst_b <= 1'b0;
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
  endtask

  initial
  begin
    repeat (100000) @(posedge clk);
    fails++;
    tally_and_finish();
  end

  initial
  begin
    logic [7:0]  a_tab [8] = '{OFS_CTL, OFS_CNT, OFS_PER, OFS_SEC, OFS_PAIR, OFS_FLT,
                               OFS_KEY, 8'h40};
    logic [15:0] e_tab [8] = '{16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h3, 16'h0, 16'h0};
    int          c_tab [5] = '{0, 1, 2, 3, 0};
    int          o_tab [5] = '{1, 1, 1, 1, 15};
    {hsel, haddr, htrans, hwrite, hwdata} = '0;
    {rst_b, idle, trip} = '0;
    strap = 1'b1;
    lock = 1'b1;
    drv_hi = 3'b101;
    drv_lo = 3'b111;
    fails = 0;
    n_compared = 0;
    reset(1'b1);
    @(posedge clk);
    for (int i = 0; i < 8; i++)
      rd_chk(a_tab[i], e_tab[i]);
    check({4'h0, pins}, 16'h0000);
    wr(OFS_CTL, 16'h7FFC);
    rd_chk(OFS_CTL, 16'h20FC);
    wr(OFS_PER, 16'hFFFF);
    rd_chk(OFS_PER, 16'h7FFF);
    wr(OFS_SEC, 16'hFFFF);
    rd_chk(OFS_SEC, 16'hFFFF);
    wr(OFS_CNT, 16'h1234);
    rd_chk(OFS_CNT, 16'h1234);
    repeat (20) @(posedge clk);
    rd_chk(OFS_CNT, 16'h1234);
    $display("test registers done");
    for (int i = 0; i < 5; i++)
    begin
      start(MODE_FREE, c_tab[i][1:0], o_tab[i][3:0], 16'd3);
      wait_ev(1'b0, k);
      wait_ev(1'b0, gap);
      check(gap[15:0], 16'((o_tab[i] + 1) * 4 * (1 << (2 * c_tab[i]))));
    end
    start(MODE_UPDN, 2'd0, 4'd0, 16'd3);
    wait_ev(1'b0, k);
    wait_ev(1'b0, gap);
    check(gap[15:0], 16'd6);
    start(MODE_UPDN_DBL, 2'd0, 4'd0, 16'd3);
    wait_ev(1'b0, k);
    wait_ev(1'b0, gap);
    check(gap[15:0], 16'd3);
    $display("test time base done");
    for (int i = 0; i < 4; i++)
    begin
      wr(OFS_SEC, {i[0], 12'h0, i[1] ? 3'd3 : 3'd0});
      repeat (3) @(posedge clk);
      k = 0;
      repeat (12)
      begin
        @(posedge clk);
        if (sp_ev === 1'b1)
          k++;
      end
      check(k[15:0], (i[1] == !i[0]) ? 16'd2 : 16'd0);
    end
    start(MODE_UPDN, 2'd3, 4'd0, 16'd3);
    wait_ev(1'b0, k);
    for (int i = 0; i < 16; i++)
    begin
      repeat (29) @(posedge clk);
      xfer(1'b0, OFS_CNT, 16'h0, rd);
      if (rd[14:0] == 15'd3)
        check(rd, 16'h0003);
      if (rd[14:0] == 15'd0)
        check(rd, 16'h8000);
    end
    wr(OFS_CTL, 16'h0000);
    wr(OFS_PER, 16'h7FFF);
    idle <= 1'b1;
    wr(OFS_CTL, 16'hA000);
    xfer(1'b0, OFS_CNT, 16'h0, rd);
    repeat (10) @(posedge clk);
    rd_chk(OFS_CNT, rd);
    wr(OFS_CTL, 16'h8000);
    repeat (10) @(posedge clk);
    xfer(1'b0, OFS_CNT, 16'h0, rd2);
    check({15'h0, rd2 !== rd}, 16'h0001);
    idle <= 1'b0;
    start(MODE_SINGLE, 2'd0, 4'd0, 16'd3);
    wait_ev(1'b0, k);
    rd_chk(OFS_CTL, 16'h0001);
    $display("test modes done");
    wr(OFS_PAIR, 16'h0777);
    check({15'h0, hresp}, 16'h0000);
    rd_chk(OFS_PAIR, 16'h0000);
    wr(OFS_KEY, KEY_SECOND);
    wr(OFS_KEY, KEY_FIRST);
    wr(OFS_PAIR, 16'h0777);
    rd_chk(OFS_PAIR, 16'h0000);
    unlock();
    xfer(1'b0, OFS_CTL, 16'h0, rd);
    wr(OFS_PAIR, 16'h0777);
    rd_chk(OFS_PAIR, 16'h0000);
    unlock();
    wr(OFS_FLT, 16'h0003);
    rd_chk(OFS_FLT, 16'h0000);
    unlock();
    wr(OFS_PAIR, 16'h0177);
    rd_chk(OFS_PAIR, 16'h0177);
    repeat (2) @(posedge clk);
    check({4'h0, pins}, {4'h0, 3'b101, 3'b011, 6'h3F});
    trip <= 2'b11;
    // sensor line, fault latch and pin register each take one edge
    repeat (4) @(posedge clk);
    check({4'h0, pins}, {4'h0, 6'h00, 6'h3F});
    rd_chk(OFS_FLT, 16'h0003);
    trip <= 2'b00;
    repeat (2) @(posedge clk);
    unlock();
    wr(OFS_FLT, 16'h0003);
    rd_chk(OFS_FLT, 16'h0000);
    lock <= 1'b0;
    wr(OFS_PAIR, 16'h0700);
    rd_chk(OFS_PAIR, 16'h0700);
    $display("test pins done");
    reset(1'b0);
    repeat (2) @(posedge clk);
    check({4'h0, pins}, {4'h0, 6'h00, 6'h3F});
    rd_chk(OFS_PAIR, 16'h0077);
    rd_chk(OFS_FLT, 16'h0003);
    $display("test second reset done");
    tally_and_finish();
  end
endmodule
